/* File: core/mon_pkg.sv */
// Constants, types and field layout of the monitor error and alert block.
// Assumes a single 125 MHz clock domain and no register bus.
//
// Notes on behaviour
// - Conversions start right after power-up.
// - Fixed channel order, optional zones skipped.
// - Full pass finishes under 100 ms.
// - Results readable any time, no handshake.
// - Status bits stay set until cleared.
// - Write one clears, only if inactive.
// - Management and host banks clear independently.
// - Legacy mode adds read-to-clear, management bank.
// - Masked events never set status bits.
// - Masking never clears an already set bit.
// - Voltage high limit FFh disables errors.
// - Temperature limit 80h disables temp, fault.
// - Input mask bits suppress input errors.
// - User throttle limit FFh disables flag.
// - Predefined throttle bits unmaskable, never alert.
// - Tach limit FFh disables tach errors.
// - Input and regulator masks suppress errors.
// - Alert stays off until enabled.
// - Sleep state forces or optionally masks events.
// - Lock protects limit registers from writes.
// - External reset clears lock, forces deep sleep.
// - Power-on resets all; external resets lock, sleep.

package mon_pkg;

	// ****************************************
	// Sizes and event vector layout
	// ****************************************
	localparam int N_SLOT   = 21;
	localparam int N_TEMP   = 5;
	localparam int N_TACH   = 4;
	localparam int N_GPI    = 8;
	localparam int N_VRH    = 2;
	localparam int N_PIN    = 11;
	localparam int N_LIM    = 26;
	localparam int LIM_TACH = 21;
	localparam int LIM_UTHR = 25;
	localparam int N_EV     = 37;
	localparam int EV_VOLT  = 5;
	localparam int EV_TACH  = 21;
	localparam int EV_GPI   = 25;
	localparam int EV_VRH   = 33;
	localparam int EV_UTHR  = 35;
	localparam int EV_PTHR  = 36;
	localparam int PIN_VRH  = 8;
	localparam int PIN_PTHR = 10;

	// Channel slots of the round robin
	localparam logic [4:0] SLOT_FIRST = 5'h00;
	localparam logic [4:0] SLOT_1B    = 5'h02;
	localparam logic [4:0] SLOT_2B    = 5'h04;
	localparam logic [4:0] SLOT_LAST  = 5'h14;

	// ****************************************
	// Limit values that disable checking
	// ****************************************
	localparam logic [7:0] VOLT_OFF = 8'hFF;
	localparam logic [7:0] TEMP_OFF = 8'h80;
	localparam logic [7:0] TACH_OFF = 8'hFF;
	localparam logic [7:0] UTHR_OFF = 8'hFF;

	// Sleep states and sleep mask fields
	localparam logic [2:0] SLEEP_S0   = 3'h0;
	localparam logic [2:0] SLEEP_DEEP = 3'h5;
	localparam int SM_GPI  = 0;
	localparam int SM_VRH  = 1;
	localparam int SM_UTHR = 2;

	// Events allowed to reach error pins and alert
	localparam logic [N_EV-1:0] ALERT_CAP = {1'b0, {36{1'b1}}};

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ     = 125;
	localparam int EXT_RST_NS  = 10000;
	localparam int EXT_RST_CYC = EXT_RST_NS * CLK_MHZ / 1000;
	localparam int XCNT_W      = 11;
	localparam int PASS_MAX_MS = 100;
	localparam int SLOT_NS     = 4000000;
	localparam int SLOT_CYC    = SLOT_NS / 1000 * CLK_MHZ;
	localparam int SEQ_CNT_W   = 29;

	typedef enum logic [1:0] {
		ST_DWELL   = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_ADVANCE = 2'b11
	} seq_state_t;

endpackage

/* File: core/bank_if.sv */
// Carrier between the monitor core and one error status bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface bank_if;
	import mon_pkg::*;
	logic [N_EV-1:0] set_ev;
	logic [N_EV-1:0] act_ev;
	logic [N_EV-1:0] clr;
	logic            rd;
	logic            rtc;
	logic [N_EV-1:0] status;
	modport bank(input set_ev, input act_ev, input clr, input rd,
		input rtc, output status);
	modport ctl(output set_ev, output act_ev, output clr, output rd,
		output rtc, input status);
endinterface

/* File: core/status_bank.sv */
// One bank of sticky error status bits with write-one-to-clear.
// Assumes set, active and clear vectors come from the same clock domain.
`timescale 1ns/1ns
module status_bank (
	input  logic mclk,
	input  logic rstn,
	bank_if.bank b
);
	import mon_pkg::*;

	typedef struct packed {
		logic [N_EV-1:0] st;
	} bank_state_t;

	bank_state_t q;
	bank_state_t d;
	logic [N_EV-1:0] wipe;

	// Clear requests, blocked while the cause persists
	assign wipe = (b.clr | {N_EV{b.rd & b.rtc}}) & ~b.act_ev;

	// Set wins over clear, bits otherwise hold
	always_comb begin
		d = q;
		d.st = b.set_ev | (q.st & ~wipe);
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign b.status = q.st;

	// ****************************************
	// Checks
	// ****************************************
	property p_hold;
		@(posedge mclk) disable iff (!rstn)
		1 |=> ($past(q.st) & ~$past(b.clr) & ~q.st &
			{N_EV{!$past(b.rd & b.rtc)}}) == '0;
	endproperty
	a_hold: assert property (p_hold)
		else $error("status bit dropped without a clear");

	property p_set_wins;
		@(posedge mclk) disable iff (!rstn)
		1 |=> ($past(b.set_ev) & ~q.st) == '0;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost against a clear");

	property p_active_blocks;
		@(posedge mclk) disable iff (!rstn)
		1 |=> ($past(q.st) & $past(b.act_ev) & ~q.st) == '0;
	endproperty
	a_active_blocks: assert property (p_active_blocks)
		else $error("bit cleared while its cause is active");

	property p_read_clear;
		@(posedge mclk) disable iff (!rstn)
		(b.rd && b.rtc) |=>
			(~$past(b.set_ev) & ~$past(b.act_ev) & q.st) == '0;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("read did not clear idle bits");

endmodule

/* File: core/monitor_error_status_alert.sv */
// Round robin sequencer, limit checks, masking and alert of the monitor.
// Assumes one clock; pins pass a two stage synchroniser first.
`timescale 1ns/1ns
module monitor_error_status_alert #(
	parameter int SLOT_CYCLES = mon_pkg::SLOT_CYC
) (
	input  logic                             mclk,
	input  logic                             rstn,
	input  logic                             ext_reset_pin,
	input  logic                             en_zone1b,
	input  logic                             en_zone2b,
	input  logic [7:0]                       adc_data,
	input  logic [mon_pkg::N_TEMP-1:0]       diode_fault,
	input  logic [mon_pkg::N_TACH-1:0][7:0]  tach_count,
	input  logic [mon_pkg::N_GPI-1:0]        general_input_pin,
	input  logic [mon_pkg::N_VRH-1:0]        regulator_overheat_input,
	input  logic                             processor_throttle_signal,
	input  logic [7:0]                       user_throttle_dur,
	input  logic                             limit_wr,
	input  logic [4:0]                       limit_idx,
	input  logic [7:0]                       limit_data,
	input  logic                             lock_set,
	input  logic                             sleep_wr,
	input  logic [2:0]                       sleep_data,
	input  logic                             start_bit,
	input  logic                             alert_en,
	input  logic                             legacy_sensor_mode,
	input  logic [mon_pkg::N_GPI-1:0]        gpi_mask,
	input  logic [mon_pkg::N_VRH-1:0]        misc_mask,
	input  logic [2:0]                       sleep_mask,
	input  logic [mon_pkg::N_EV-1:0]         mgmt_clr,
	input  logic [mon_pkg::N_EV-1:0]         host_clr,
	input  logic                             mgmt_rd,
	input  logic [4:0]                       value_idx,
	output logic                             conv_start_q,
	output logic [4:0]                       chan_sel_q,
	output logic [7:0]                       value_data_q,
	output logic [mon_pkg::N_EV-1:0]         mgmt_status_q,
	output logic [mon_pkg::N_EV-1:0]         host_status_q,
	output logic                             management_side_error_pin,
	output logic                             host_error_pin,
	output logic                             alert_oe,
	output logic                             alert_out,
	output logic                             lock_q,
	output logic [2:0]                       sleep_state_q
);
	import mon_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		seq_state_t                 st;
		logic [SEQ_CNT_W-1:0]       cnt;
		logic [4:0]                 slot;
		logic                       conv_start;
		logic [N_SLOT-1:0][7:0]     val;
		logic [N_LIM-1:0][7:0]      lim;
		logic                       lock;
		logic [2:0]                 sleep;
		logic [XCNT_W-1:0]          xcnt;
		logic                       xdone;
		logic                       xr1;
		logic                       xr2;
		logic [N_PIN-1:0]           p1;
		logic [N_PIN-1:0]           p2;
		logic                       merr;
		logic                       herr;
		logic                       alert;
		logic                       alert_lvl;
		logic [7:0]                 rd_data;
	} mon_state_t;

	mon_state_t      s_q;
	mon_state_t      s_d;
	logic [N_EV-1:0] ev_raw;
	logic [N_EV-1:0] ev_off;
	logic [N_EV-1:0] ev_set;
	logic            deep;
	logic            asleep;
	logic            gate;

	bank_if mgmt_if ();
	bank_if host_if ();

	// ****************************************
	// Functions
	// ****************************************
	// Limit compare, disabled by the off value
	function automatic logic over_limit(input logic [7:0] v,
		input logic [7:0] l, input logic [7:0] off);
		return (l != off) && (v > l);
	endfunction

	// Next slot in order, skipping unused optional zones
	function automatic logic [4:0] next_slot(input logic [4:0] s,
		input logic en1b, input logic en2b);
		logic [4:0] n;
		n = (s == SLOT_LAST) ? SLOT_FIRST : s + 5'h01;
		if ((n == SLOT_1B && !en1b) || (n == SLOT_2B && !en2b)) begin
			n = n + 5'h01;
		end
		return n;
	endfunction

	// Power-on values: limits at their disabling defaults
	function automatic mon_state_t reset_state();
		mon_state_t r;
		r = '0;
		r.st = ST_DWELL;
		r.conv_start = 1'b1;
		r.sleep = SLEEP_DEEP;
		for (int k = 0; k < N_LIM; k++) begin
			if (k < N_TEMP) begin
				r.lim[k] = TEMP_OFF;
			end else if (k < LIM_TACH) begin
				r.lim[k] = VOLT_OFF;
			end else if (k < LIM_UTHR) begin
				r.lim[k] = TACH_OFF;
			end else begin
				r.lim[k] = UTHR_OFF;
			end
		end
		return r;
	endfunction

	// ****************************************
	// Event detection and masking
	// ****************************************
	// Sleep and start gating
	assign deep   = (s_q.sleep == SLEEP_DEEP);
	assign asleep = (s_q.sleep != SLEEP_S0);
	assign gate   = !start_bit || deep;

	// Temperature and voltage channels
	genvar k;
	generate
		for (k = 0; k < N_SLOT; k++) begin : g_chan
			if (k < N_TEMP) begin : g_temp
				assign ev_raw[k] = over_limit(s_q.val[k], s_q.lim[k],
					TEMP_OFF) || (s_q.lim[k] != TEMP_OFF &&
					diode_fault[k]);
			end else begin : g_volt
				assign ev_raw[k] = over_limit(s_q.val[k], s_q.lim[k],
					VOLT_OFF);
			end
			assign ev_off[k] = gate;
		end
		// Fan tachometers
		for (k = 0; k < N_TACH; k++) begin : g_tach
			assign ev_raw[EV_TACH+k] = over_limit(tach_count[k],
				s_q.lim[LIM_TACH+k], TACH_OFF);
			assign ev_off[EV_TACH+k] = gate;
		end
		// General inputs
		for (k = 0; k < N_GPI; k++) begin : g_gpi
			assign ev_raw[EV_GPI+k] = s_q.p2[k];
			assign ev_off[EV_GPI+k] = !start_bit || gpi_mask[k] ||
				(asleep && sleep_mask[SM_GPI]);
		end
		// Regulator overheat inputs
		for (k = 0; k < N_VRH; k++) begin : g_vrh
			assign ev_raw[EV_VRH+k] = s_q.p2[PIN_VRH+k];
			assign ev_off[EV_VRH+k] = !start_bit || misc_mask[k] ||
				(asleep && sleep_mask[SM_VRH]);
		end
	endgenerate

	// User throttle duration against its limit
	assign ev_raw[EV_UTHR] = (s_q.lim[LIM_UTHR] != UTHR_OFF) &&
		(user_throttle_dur >= s_q.lim[LIM_UTHR]);
	assign ev_off[EV_UTHR] = !start_bit ||
		(asleep && sleep_mask[SM_UTHR]);

	// Predefined throttle threshold, never masked
	assign ev_raw[EV_PTHR] = s_q.p2[PIN_PTHR];
	assign ev_off[EV_PTHR] = 1'b0;

	assign ev_set = ev_raw & ~ev_off;

	// ****************************************
	// Status banks
	// ****************************************
	// Separate clears for each bank
	assign mgmt_if.set_ev = ev_set;
	assign mgmt_if.act_ev = ev_raw;
	assign mgmt_if.clr    = mgmt_clr;
	assign mgmt_if.rd     = mgmt_rd;
	assign mgmt_if.rtc    = legacy_sensor_mode;
	assign host_if.set_ev = ev_set;
	assign host_if.act_ev = ev_raw;
	assign host_if.clr    = host_clr;
	assign host_if.rd     = 1'b0;
	assign host_if.rtc    = 1'b0;

	status_bank u_mgmt (
		.mclk (mclk),
		.rstn (rstn),
		.b    (mgmt_if.bank)
	);

	status_bank u_host (
		.mclk (mclk),
		.rstn (rstn),
		.b    (host_if.bank)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		// Pin synchronisers
		s_d.xr1 = ext_reset_pin;
		s_d.xr2 = s_q.xr1;
		s_d.p1 = {processor_throttle_signal, regulator_overheat_input,
			general_input_pin};
		s_d.p2 = s_q.p1;
		// Round robin sequencer, running from reset
		s_d.conv_start = 1'b0;
		case (s_q.st)
			ST_DWELL: begin
				if (s_q.cnt == SEQ_CNT_W'(SLOT_CYCLES - 1)) begin
					s_d.st = ST_CAPTURE;
				end else begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			ST_CAPTURE: begin
				s_d.val[s_q.slot] = adc_data;
				s_d.st = ST_ADVANCE;
			end
			ST_ADVANCE: begin
				s_d.slot = next_slot(s_q.slot, en_zone1b, en_zone2b);
				s_d.cnt = '0;
				s_d.conv_start = 1'b1;
				s_d.st = ST_DWELL;
			end
			default: begin
				s_d.st = ST_DWELL;
			end
		endcase
		// Limit writes, refused while locked
		if (limit_wr && !s_q.lock && limit_idx < 5'(N_LIM)) begin
			s_d.lim[limit_idx] = limit_data;
		end
		if (lock_set) begin
			s_d.lock = 1'b1;
		end
		if (sleep_wr) begin
			s_d.sleep = sleep_data;
		end
		// External reset held long enough: unlock, deep sleep
		if (s_q.xr2) begin
			if (s_q.xcnt != XCNT_W'(EXT_RST_CYC - 1)) begin
				s_d.xcnt = s_q.xcnt + 1'b1;
			end else if (!s_q.xdone) begin
				s_d.lock = 1'b0;
				s_d.sleep = SLEEP_DEEP;
				s_d.xdone = 1'b1;
			end
		end else begin
			s_d.xcnt = '0;
			s_d.xdone = 1'b0;
		end
		// Error pins and alert from alert-capable status
		s_d.merr = |(mgmt_if.status & ALERT_CAP);
		s_d.herr = |(host_if.status & ALERT_CAP);
		s_d.alert = alert_en && |(mgmt_if.status & ALERT_CAP);
		s_d.alert_lvl = 1'b0;
		// Value readback
		if (value_idx < 5'(N_SLOT)) begin
			s_d.rd_data = s_q.val[value_idx];
		end else begin
			s_d.rd_data = '0;
		end
	end

	// Power-on reset covers every register
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s_q <= reset_state();
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign conv_start_q              = s_q.conv_start;
	assign chan_sel_q                = s_q.slot;
	assign value_data_q              = s_q.rd_data;
	assign mgmt_status_q             = mgmt_if.status;
	assign host_status_q             = host_if.status;
	assign management_side_error_pin = s_q.merr;
	assign host_error_pin            = s_q.herr;
	assign alert_oe                  = s_q.alert;
	assign alert_out                 = s_q.alert_lvl;
	assign lock_q                    = s_q.lock;
	assign sleep_state_q             = s_q.sleep;

	// ****************************************
	// Checks
	// ****************************************
	property p_capture;
		@(posedge mclk) disable iff (!rstn)
		s_q.st == ST_CAPTURE |=>
			s_q.val[$past(s_q.slot)] == $past(adc_data);
	endproperty
	a_capture: assert property (p_capture)
		else $error("conversion result not stored");

	property p_wrap;
		@(posedge mclk) disable iff (!rstn)
		(s_q.st == ST_ADVANCE && s_q.slot == SLOT_LAST) |=>
			(s_q.slot == SLOT_FIRST) && conv_start_q;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("sequence did not wrap to first slot");

	property p_alert_off;
		@(posedge mclk) disable iff (!rstn)
		!alert_en |=> !alert_oe;
	endproperty
	a_alert_off: assert property (p_alert_off)
		else $error("alert driven while disabled");

	property p_alert_on;
		@(posedge mclk) disable iff (!rstn)
		(alert_en && |(mgmt_status_q & ALERT_CAP)) |=> alert_oe;
	endproperty
	a_alert_on: assert property (p_alert_on)
		else $error("alert missing for set status");

	property p_locked;
		@(posedge mclk) disable iff (!rstn)
		s_q.lock |=> $stable(s_q.lim);
	endproperty
	a_locked: assert property (p_locked)
		else $error("limit changed while locked");

	property p_ext_reset;
		@(posedge mclk) disable iff (!rstn)
		(s_q.xr2 && !s_q.xdone && !sleep_wr && !lock_set &&
			s_q.xcnt == XCNT_W'(EXT_RST_CYC - 1)) |=>
			!lock_q && sleep_state_q == SLEEP_DEEP;
	endproperty
	a_ext_reset: assert property (p_ext_reset)
		else $error("external reset did not unlock and sleep");

	property p_volt_off;
		@(posedge mclk) disable iff (!rstn)
		s_q.lim[EV_VOLT] == VOLT_OFF |-> !ev_set[EV_VOLT];
	endproperty
	a_volt_off: assert property (p_volt_off)
		else $error("voltage error with disabling limit");

	property p_no_pthr_pin;
		@(posedge mclk) disable iff (!rstn)
		!(|(mgmt_status_q & ALERT_CAP)) |=> !management_side_error_pin;
	endproperty
	a_no_pthr_pin: assert property (p_no_pthr_pin)
		else $error("error pin raised without capable status");

endmodule

/* File: verification/adc_frontend_model.sv */
// Stand-in for the analog front end feeding the monitor core.
// Assumes the slot select is a flop output that is stable over a slot.
`timescale 1ns/1ns
module adc_frontend_model (
	input  wire logic       mclk,
	input  wire logic [4:0] chan_sel_q,
	output logic [7:0]      adc_data
);
	// Code is C0h plus slot: above the temperature disable limit
	initial adc_data = 8'hC0;
	always @(negedge mclk) begin
		adc_data <= 8'hC0 | {3'h0, chan_sel_q};
	end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the monitor error, status and alert block.
// Assumes the analog stand-in model; inputs change on falling edges.
`timescale 1ns/1ns
module tb_top;
	import mon_pkg::*;
	localparam int SC = 8;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic ext_reset_pin = 1'b0, en_zone1b = 1'b0, en_zone2b = 1'b1;
	logic [7:0] adc_data, user_throttle_dur = 8'h00, limit_data = 8'h00;
	logic [N_TEMP-1:0] diode_fault = '0;
	logic [N_TACH-1:0][7:0] tach_count = '0;
	logic [N_GPI-1:0] general_input_pin = '0, gpi_mask = '0;
	logic [N_VRH-1:0] regulator_overheat_input = '0, misc_mask = '0;
	logic processor_throttle_signal = 1'b0, limit_wr = 1'b0;
	logic lock_set = 1'b0, sleep_wr = 1'b0, start_bit = 1'b0;
	logic alert_en = 1'b0, legacy_sensor_mode = 1'b0, mgmt_rd = 1'b0;
	logic [4:0] limit_idx = 5'h00, value_idx = 5'h00;
	logic [2:0] sleep_data = 3'h0, sleep_mask = 3'h0;
	logic [N_EV-1:0] mgmt_clr = '0, host_clr = '0;
	logic conv_start_q, management_side_error_pin, host_error_pin;
	logic alert_oe, alert_out, lock_q;
	logic [4:0] chan_sel_q;
	logic [7:0] value_data_q;
	logic [N_EV-1:0] mgmt_status_q, host_status_q;
	logic [2:0] sleep_state_q;
	int n_errors = 0;
	int n_compared = 0;

	// Clock of 8 ns period
	always #4 mclk = ~mclk;

	monitor_error_status_alert #(.SLOT_CYCLES(SC)) dut (
		.mclk, .rstn, .ext_reset_pin, .en_zone1b, .en_zone2b, .adc_data,
		.diode_fault, .tach_count, .general_input_pin,
		.regulator_overheat_input, .processor_throttle_signal,
		.user_throttle_dur, .limit_wr, .limit_idx, .limit_data, .lock_set,
		.sleep_wr, .sleep_data, .start_bit, .alert_en, .legacy_sensor_mode,
		.gpi_mask, .misc_mask, .sleep_mask, .mgmt_clr, .host_clr, .mgmt_rd,
		.value_idx, .conv_start_q, .chan_sel_q, .value_data_q,
		.mgmt_status_q, .host_status_q, .management_side_error_pin,
		.host_error_pin, .alert_oe, .alert_out, .lock_q, .sleep_state_q);

	adc_frontend_model afe (.mclk(mclk), .chan_sel_q(chan_sel_q),
		.adc_data(adc_data));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic report_and_stop;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Bounded wait for the next conversion start, returns cycles waited
	task automatic wait_start(output int t);
		t = 0;
		do begin
			cyc(1);
			t++;
		end while (conv_start_q !== 1'b1 && t < 100);
		if (t >= 100) begin
			n_errors++;
			report_and_stop();
		end
	endtask

	// One-cycle pulse on the limit write strobe
	task automatic put_limit(input logic [4:0] idx, input logic [7:0] d);
		limit_idx = idx;
		limit_data = d;
		limit_wr = 1'b1;
		cyc(1);
		limit_wr = 1'b0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_sequence;
		int t;
		chk("conv_start_q", conv_start_q, 1'b1);
		for (int k = 0; k <= 20; k++) begin
			chk("chan_sel_q", chan_sel_q,
				(k == 20) ? 0 : (k < 2) ? k : k + 1);
			if (k < 20) begin
				wait_start(t);
				chk("slot_period", t, SC + 2);
			end
		end
		chk("pass_short", N_SLOT * (SLOT_CYC + 2) * 8 < 100000000, 1);
		value_idx = 5'h07;
		cyc(2);
		chk("value_data_q", value_data_q, 8'hC7);
	endtask

	task automatic t_setup;
		start_bit = 1'b1;
		sleep_data = SLEEP_S0;
		sleep_wr = 1'b1;
		cyc(1);
		sleep_wr = 1'b0;
		cyc(1);
		chk("sleep_state_q", sleep_state_q, SLEEP_S0);
		chk("alert_oe", alert_oe, 1'b0);
	endtask

	task automatic t_sticky;
		general_input_pin[0] = 1'b1;
		cyc(5);
		chk("mgmt_gpi0", mgmt_status_q[EV_GPI], 1'b1);
		chk("alert_off", alert_oe, 1'b0);
		mgmt_clr[EV_GPI] = 1'b1;
		cyc(1);
		mgmt_clr = '0;
		general_input_pin[0] = 1'b0;
		cyc(4);
		chk("clr_active", mgmt_status_q[EV_GPI], 1'b1);
		alert_en = 1'b1;
		gpi_mask[0] = 1'b1;
		cyc(3);
		chk("alert_on", alert_oe, 1'b1);
		chk("alert_out", alert_out, 1'b0);
		chk("mask_keeps", mgmt_status_q[EV_GPI], 1'b1);
		mgmt_clr[EV_GPI] = 1'b1;
		cyc(1);
		mgmt_clr = '0;
		cyc(2);
		chk("mgmt_clr", mgmt_status_q[EV_GPI], 1'b0);
		chk("host_kept", host_status_q[EV_GPI], 1'b1);
		chk("mgmt_pin", management_side_error_pin, 1'b0);
		chk("host_pin", host_error_pin, 1'b1);
		chk("alert_gone", alert_oe, 1'b0);
		general_input_pin[0] = 1'b1;
		misc_mask[0] = 1'b1;
		regulator_overheat_input[0] = 1'b1;
		cyc(5);
		chk("gpi_masked", mgmt_status_q[EV_GPI], 1'b0);
		chk("vrh_masked", mgmt_status_q[EV_VRH], 1'b0);
		general_input_pin[0] = 1'b0;
		cyc(3);
		host_clr = '1;
		cyc(1);
		host_clr = '0;
		cyc(2);
		chk("host_empty", host_status_q, '0);
	endtask

	task automatic t_legacy;
		general_input_pin[1] = 1'b1;
		cyc(5);
		general_input_pin[1] = 1'b0;
		legacy_sensor_mode = 1'b1;
		cyc(3);
		mgmt_rd = 1'b1;
		cyc(1);
		mgmt_rd = 1'b0;
		cyc(2);
		chk("rd_clear", mgmt_status_q[EV_GPI+1], 1'b0);
		chk("host_rd", host_status_q[EV_GPI+1], 1'b1);
		legacy_sensor_mode = 1'b0;
		host_clr = '1;
		cyc(1);
		host_clr = '0;
	endtask

	task automatic t_throttle;
		processor_throttle_signal = 1'b1;
		user_throttle_dur = 8'hFF;
		tach_count = {N_TACH{8'hFF}};
		cyc(6);
		chk("pthr_set", mgmt_status_q[EV_PTHR], 1'b1);
		chk("uthr_off", mgmt_status_q[EV_UTHR], 1'b0);
		chk("tach_off", mgmt_status_q[EV_GPI-1:EV_TACH], 4'h0);
		chk("pins_quiet", {management_side_error_pin, host_error_pin,
			alert_oe}, 3'h0);
	endtask

	task automatic t_limits;
		diode_fault = '1;
		cyc(12 * (SC + 2) * 2);
		chk("temp_off", mgmt_status_q[EV_VOLT-1:0], 5'h00);
		chk("volt_off", mgmt_status_q[EV_TACH-1:EV_VOLT], 16'h0000);
		put_limit(5'd5, 8'h10);
		lock_set = 1'b1;
		cyc(1);
		lock_set = 1'b0;
		put_limit(5'd6, 8'h10);
		chk("lock_q", lock_q, 1'b1);
		cyc(12 * (SC + 2) * 2);
		chk("volt5_err", mgmt_status_q[EV_VOLT], 1'b1);
		chk("locked6", mgmt_status_q[EV_VOLT+1], 1'b0);
		ext_reset_pin = 1'b1;
		cyc(EXT_RST_CYC - 20);
		chk("lock_early", lock_q, 1'b1);
		cyc(30);
		chk("lock_ext", lock_q, 1'b0);
		chk("sleep_ext", sleep_state_q, SLEEP_DEEP);
		chk("status_ext", mgmt_status_q[EV_VOLT], 1'b1);
		ext_reset_pin = 1'b0;
	endtask

	// Sleep based masking, user throttle limit, optional zone order
	task automatic t_sleep;
		int t;
		put_limit(5'h06, 8'h10);
		cyc(4);
		chk("deep_masks", mgmt_status_q[EV_VOLT+1], 1'b0);
		sleep_mask = 3'h1;
		general_input_pin[2] = 1'b1;
		sleep_data = 3'h3;
		sleep_wr = 1'b1;
		cyc(1);
		sleep_wr = 1'b0;
		cyc(5);
		chk("sleep_gpi_masked", mgmt_status_q[EV_GPI+2], 1'b0);
		chk("sleep_volt_open", mgmt_status_q[EV_VOLT+1], 1'b1);
		sleep_mask = 3'h0;
		cyc(4);
		chk("sleep_gpi_open", mgmt_status_q[EV_GPI+2], 1'b1);
		general_input_pin[2] = 1'b0;
		put_limit(5'h19, 8'h80);
		cyc(3);
		chk("uthr_on", mgmt_status_q[EV_UTHR], 1'b1);
		en_zone1b = 1'b1;
		en_zone2b = 1'b0;
		for (int n = 0; n < 25 && chan_sel_q !== 5'h01; n++) begin
			wait_start(t);
		end
		wait_start(t);
		chk("chan_1b", chan_sel_q, 5'h02);
		wait_start(t);
		chk("chan_2a", chan_sel_q, 5'h03);
		wait_start(t);
		chk("chan_skip_2b", chan_sel_q, 5'h05);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		cyc(4);
		rstn = 1'b1;
		t_sequence();
		t_setup();
		t_sticky();
		t_legacy();
		t_throttle();
		t_limits();
		t_sleep();
		report_and_stop();
	end
endmodule
